// file: fcm_regs.svh
// Constants of the fuse check mode block: reset values and timing counts.
// Assumes inclusion by bare name from the package and design files.
// What this block does
// R1: Enter mode on first TMS fall or low-at-reset.
// R2: Leave mode on second TMS rise after reset.
// R3: Once left, stay off until next reset.
// R4: Sense current only while mode active and TMS low.
// R5: Test pin taken low ends mode and current.
// R6: Tool keeps TMS high to avoid current.
// R7: Protection needs blown fuse and key-guarded loader.
// R8: Reset clears flag and rise counter, re-arms.
`ifndef FCM_REGS_SVH
`define FCM_REGS_SVH

`define FCM_SYNC_STAGES    3
`define FCM_RISE_CNT_RST   2'h0
`define FCM_RISE_CNT_LEAVE 2'h2
`define FCM_KEY_BITS       256

`endif

// file: fcm_pkg.sv
// Types shared by the fuse check mode block.
// Assumes fcm_regs.svh sits in the same folder.
`include "fcm_regs.svh"

package fcm_pkg;

  typedef enum logic [1:0] {
    FCM_ARMED,
    FCM_ACTIVE,
    FCM_SPENT
  } fcm_state_e;

  typedef logic [1:0] fcm_rise_t;

endpackage

// file: fcm_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes a single clock; the input comes from an asynchronous pin.
module fcm_pin_sync #(
  parameter logic RST_LEVEL = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic pin_in,
  output logic      pin_level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } fcm_sync_s;

  fcm_sync_s st_ff;
  fcm_sync_s nxt_st;

  always_comb begin
    nxt_st     = st_ff;
    nxt_st.s1  = pin_in;
    nxt_st.s2  = st_ff.s1;
    nxt_st.s3  = st_ff.s2;
    // A change counts only once stages two and three agree.
    if (st_ff.s2 == st_ff.s3) begin
      nxt_st.lvl = st_ff.s3;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= {4{RST_LEVEL}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_level = st_ff.lvl;

endmodule

// file: fcm_fuse_check.sv
// Fuse check mode control: tracks TMS after power-on reset and gates the fuse sense current.
// Assumes reset is the synchronous power-on reset; tms and test_pin are asynchronous pins.
`include "fcm_regs.svh"

module fcm_fuse_check (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic tms,
  input  wire logic test_pin,
  input  wire logic fuse_blown,
  input  wire logic key_checked,
  output logic      check_mode,
  output logic      sense_en,
  output logic      protect_ok
);

  typedef struct packed {
    fcm_pkg::fcm_state_e state;
    fcm_pkg::fcm_rise_t  rises;
    logic                tms_prev;
    logic                first;
    logic                test_prev;
    logic                sense;
    logic                prot;
  } fcm_top_s;

  fcm_top_s st_ff;
  fcm_top_s nxt_st;
  logic     tms_lvl;
  logic     test_lvl;
  logic     tms_fall;
  logic     tms_rise;
  logic     test_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. TMS idles high, so it resets high to avoid a false fall.

  fcm_pin_sync #(.RST_LEVEL(1'b1)) u_tms_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    (tms),
    .pin_level (tms_lvl)
  );

  fcm_pin_sync #(.RST_LEVEL(1'b0)) u_test_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_in    (test_pin),
    .pin_level (test_lvl)
  );

  assign tms_fall  = st_ff.tms_prev & ~tms_lvl;
  assign tms_rise  = ~st_ff.tms_prev & tms_lvl;
  assign test_fall = st_ff.test_prev & ~test_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine.

  always_comb begin
    nxt_st           = st_ff;
    nxt_st.tms_prev  = tms_lvl;
    nxt_st.test_prev = test_lvl;
    nxt_st.first     = 1'b0;
    if (tms_rise && st_ff.rises != `FCM_RISE_CNT_LEAVE) begin
      nxt_st.rises = st_ff.rises + 2'h1;
    end
    case (st_ff.state)
      fcm_pkg::FCM_ARMED: begin
        // First sample after reset stands for TMS held low during power up.
        if (tms_fall || (st_ff.first && !tms_lvl)) begin
          nxt_st.state = fcm_pkg::FCM_ACTIVE; // see R1
        end
      end
      fcm_pkg::FCM_ACTIVE: begin
        if (test_fall) begin
          nxt_st.state = fcm_pkg::FCM_SPENT; // see R5
        end else if (tms_rise && st_ff.rises == `FCM_RISE_CNT_LEAVE - 2'h1) begin
          nxt_st.state = fcm_pkg::FCM_SPENT; // see R2
        end
      end
      fcm_pkg::FCM_SPENT: begin
        nxt_st.state = fcm_pkg::FCM_SPENT; // see R3
      end
      default: begin
        nxt_st.state = fcm_pkg::FCM_SPENT;
      end
    endcase
    // Registered so the current path never glitches on a pin edge.
    nxt_st.sense = (nxt_st.state == fcm_pkg::FCM_ACTIVE) && !tms_lvl; // see R4
    // The key flag is a loader verdict; this block only combines it with the fuse.
    nxt_st.prot  = fuse_blown && key_checked; // see R7
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff.state     <= fcm_pkg::FCM_ARMED; // see R8
      st_ff.rises     <= `FCM_RISE_CNT_RST;
      st_ff.tms_prev  <= 1'b1;
      st_ff.first     <= 1'b1;
      st_ff.test_prev <= 1'b0;
      st_ff.sense     <= 1'b0;
      st_ff.prot      <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign check_mode = (st_ff.state == fcm_pkg::FCM_ACTIVE);
  assign sense_en   = st_ff.sense;
  assign protect_ok = st_ff.prot;

endmodule

// file: fcm_fuse_check_asserts.sv
// Port checks for the fuse check mode block.
// Assumes one clock and a synchronous high reset.
module fcm_fuse_check_asserts (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tms,
  input wire logic test_pin,
  input wire logic fuse_blown,
  input wire logic key_checked,
  input wire logic check_mode,
  input wire logic sense_en,
  input wire logic protect_ok
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  rst_clear_a: assert property ($past(reset) |-> !check_mode && !sense_en) else $error("rst");
  sense_gate_a: assert property (sense_en |-> check_mode) else $error("sense");
  stay_off_a: assert property ($fell(check_mode) |=> !check_mode [*8]) else $error("off");
  // Entry needs mode-select low through the synchroniser.
  entry_a: assert property ($rose(check_mode) |-> !$past(tms, 3)) else $error("entry");
  pin_end_a: assert property ($fell(test_pin) && check_mode |-> ##[1:8] !check_mode) else $error("pin");
  prot_ok_a: assert property (!$past(reset) |-> protect_ok == $past(fuse_blown && key_checked))
    else $error("prot");
  cover property ($rose(sense_en));
  cover property ($fell(sense_en) && check_mode);
  cover property ($fell(check_mode));
endmodule
bind fcm_fuse_check fcm_fuse_check_asserts u_chk (.*);

// file: fcm_tool.sv
// Model of the test tool that drives the mode-select and test pins.
// Assumes the bench calls set; pins move on the falling edge.
module fcm_tool (
  input  wire logic clk_sys,
  output logic      tms,
  output logic      test_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idling high keeps the sense current off between sessions.
  initial tms = 1'b1;
  initial test_pin = 1'b1;
  task automatic set(logic t, logic p);
    @(negedge clk_sys);
    tms = t;
    test_pin = p;
  endtask
endmodule

// file: fcm_fuse_check_tb.sv
// Bench for the fuse check mode block.
// Assumes outputs settle within eight cycles of a pin change.
module fcm_fuse_check_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic fuse_blown = 1'b0;
  logic key_checked = 1'b0;
  wire logic tms, test_pin, check_mode, sense_en, protect_ok;
  int failures = 0;
  int compares = 0;
  logic [2:0] notes[$];
  always #12.5 clk_sys = ~clk_sys;
  fcm_tool u_fcm_tool (.*);
  fcm_fuse_check u_fcm_fuse_check (.*);
  task automatic check(logic [2:0] seen, logic [2:0] want);
    compares++;
    if (seen !== want) begin
      failures++;
      $display("BAD %0t got %b want %b", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic por(logic t);
    u_fcm_tool.set(t, 1'b1);
    reset = 1'b1;
    repeat (4) @(negedge clk_sys);
    reset = 1'b0;
  endtask
  task automatic step(logic t, logic p, logic m, logic s);
    u_fcm_tool.set(t, p);
    {fuse_blown, key_checked} = 2'($urandom);
    repeat (8) @(negedge clk_sys);
    notes.push_back({m, s, fuse_blown & key_checked});
  endtask
  always @(negedge clk_sys) begin
    if (notes.size() > 0) begin
      check({check_mode, sense_en, protect_ok}, notes.pop_front());
    end
  end
  initial begin
    void'($urandom(96));
    por(1'b0);
    step(1'b0, 1'b1, 1'b1, 1'b1);
    step(1'b1, 1'b1, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b1, 1'b1);
    step(1'b1, 1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b0);
    $display("test low at reset done");
    por(1'b1);
    step(1'b1, 1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b1, 1'b1);
    step(1'b0, 1'b0, 1'b0, 1'b0);
    step(1'b1, 1'b1, 1'b0, 1'b0);
    step(1'b0, 1'b1, 1'b0, 1'b0);
    $display("test pin end done");
    repeat (2) @(negedge clk_sys);
    wrap_up();
  end
  initial begin
    #20000;
    failures++;
    wrap_up();
  end
endmodule
